// *** core/tmr0sp_timer.sv ***
/*
  8-bit timer/counter with overflow interrupt and a prescaler shared with
  the watchdog. assumes synchronous pins, one clock per oscillator period,
  and a watchdog outside that supplies ticks and takes the divided ticks.
*/
// Our own choice: the strobed register port.
// Notes on behaviour
// [RQ1] source bit zero: count each instruction cycle when prescaler is elsewhere
// [RQ2] a counter write holds counting off for two instruction cycles
// [RQ3] source bit one: count edges of the external count input
// [RQ4] edge bit zero counts rising edges, one counts falling edges
// [RQ5] one prescaler, timer or watchdog; the other runs undivided
// [RQ6] software can neither read nor write the prescaler count
// [RQ7] assign bit one gives prescaler to watchdog, zero to timer
// [RQ8] ratio codes give 1:2..1:256 for timer, 1:1..1:128 for watchdog
// [RQ9] counter write clears prescaler when timer owns it, assignment kept
// [RQ10] watchdog clear clears prescaler when watchdog owns it
// [RQ11] wrap from FFh to 00h sets the overflow flag
// [RQ12] overflow request masked while its enable bit is zero; an overflow event whose mask bit is set still raises o_irq
// [RQ13] software clears the overflow flag; hardware never does
// [RQ14] counter stops during sleep, so no wake from overflow
// [RQ15] prescaler output sampled in Q2 and Q4 phases
// [RQ16] external input stays high two periods, then low two periods
// [RQ17] without prescaler the sampler takes the input directly
// [RQ18] software clears counter then watchdog before moving the prescaler
`timescale 1ns/1ps
module tmr0sp_timer
  import tmr0sp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_count_input,
  input wire logic i_sleep,
  input wire logic i_wdt_tick,
  input wire logic i_watchdog_clear_instr,
  output logic o_wdt_tick,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tmr0sp_phase_t phase_q;
  logic [7:0] count_q;
  logic [7:0] irqctl_q;
  logic [7:0] option_q;
  logic [7:0] evt_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic [3:0] inhibit_q;
  logic ext_prev_q;
  logic samp_q;
  logic wdt_out_q;

  logic src_ext;
  logic edge_fall;
  logic psc_wdt;
  logic [2:0] ratio;
  logic wr_count;
  logic wr_irqctl;
  logic wr_option;
  logic wr_mask;
  logic rd_evt;
  logic ext_lvl;
  logic ext_rise;
  logic inst_level;
  logic tmr_tick;
  logic tmr_level;
  logic psc_tick;
  logic psc_clear;
  logic [SHIFT_W-1:0] psc_shift;
  logic psc_level;
  logic psc_pulse;
  logic src_level;
  logic sample_en;
  logic inc;
  logic ovf;
  logic wdt_evt;

  // ----------------------------------------------------------------
  // option fields
  // ----------------------------------------------------------------
  assign src_ext = option_q[OPT_SRC_BIT];
  assign edge_fall = option_q[OPT_EDGE_BIT];
  assign psc_wdt = option_q[OPT_ASSIGN_BIT]; // [RQ7]
  assign ratio = option_q[OPT_RATIO_MSB:OPT_RATIO_LSB];

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_count = 1'b0;
    wr_irqctl = 1'b0;
    wr_option = 1'b0;
    wr_mask = 1'b0;
    // prescaler count has no address at all [RQ6]
    if (i_wr && i_addr == ADDR_COUNT) begin
      wr_count = 1'b1;
    end else if (i_wr && i_addr == ADDR_IRQCTL) begin
      wr_irqctl = 1'b1;
    end else if (i_wr && i_addr == ADDR_OPTION) begin
      wr_option = 1'b1;
    end else if (i_wr && i_addr == ADDR_EVT_MASK) begin
      wr_mask = 1'b1;
    end
  end

  assign rd_evt = i_rd && (i_addr == ADDR_EVT_STATUS);

  // ----------------------------------------------------------------
  // phase clock
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_q <= PH_Q1;
    end else if (i_ce) begin
      case (phase_q)
        PH_Q1: phase_q <= PH_Q2;
        PH_Q2: phase_q <= PH_Q3;
        PH_Q3: phase_q <= PH_Q4;
        default: phase_q <= PH_Q1;
      endcase
    end
  end

  // instruction clock high in Q3 and Q4, one tick at Q1
  assign inst_level = (phase_q == PH_Q3) || (phase_q == PH_Q4);

  // ----------------------------------------------------------------
  // count source
  // ----------------------------------------------------------------
  assign ext_lvl = i_ext_count_input ^ edge_fall; // [RQ4]
  assign ext_rise = ext_lvl & ~ext_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ext_prev_q <= 1'b1; // reset option counts falling edges of an idle-low pin
    end else if (i_ce) begin
      ext_prev_q <= ext_lvl;
    end
  end

  // external edges or instruction cycles, stopped in sleep [RQ1] [RQ3] [RQ14]
  assign tmr_tick = ~i_sleep & (src_ext ? ext_rise : (phase_q == PH_Q1));
  assign tmr_level = src_ext ? ext_lvl : inst_level;

  // ----------------------------------------------------------------
  // shared prescaler
  // ----------------------------------------------------------------
  assign psc_tick = psc_wdt ? i_wdt_tick : tmr_tick; // [RQ5]
  // timer ratio is one stage deeper than the watchdog ratio [RQ8]
  assign psc_shift = psc_wdt ? {1'b0, ratio} : ({1'b0, ratio} + SHIFT_ONE);
  // [RQ9] [RQ10]
  assign psc_clear = (wr_count & ~psc_wdt) | (i_watchdog_clear_instr & psc_wdt);

  tmr0sp_prescaler u_psc (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_clear(psc_clear),
    .i_tick(psc_tick),
    .i_level(tmr_level),
    .i_shift(psc_shift),
    .o_level(psc_level),
    .o_pulse(psc_pulse)
  );

  // timer bypasses the division when the watchdog owns it [RQ17]
  assign src_level = psc_wdt ? tmr_level : psc_level;

  // ----------------------------------------------------------------
  // phase sampler
  // ----------------------------------------------------------------
  // [RQ15]
  assign sample_en = ~i_sleep & ((phase_q == PH_Q2) || (phase_q == PH_Q4));

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      samp_q <= 1'b1;
    end else if (i_ce && sample_en) begin
      samp_q <= src_level;
    end
  end

  // [RQ2] [RQ14]
  assign inc = sample_en & src_level & ~samp_q & (inhibit_q == INHIBIT_ZERO) & ~wr_count;
  assign ovf = inc & (count_q == COUNT_MAX);

  // ----------------------------------------------------------------
  // write inhibit
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      inhibit_q <= INHIBIT_ZERO;
    end else if (i_ce) begin
      if (wr_count) begin
        inhibit_q <= INHIBIT_CLKS; // [RQ2]
      end else if (inhibit_q != INHIBIT_ZERO) begin
        inhibit_q <= inhibit_q - INHIBIT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_q <= RST_COUNT;
    end else if (i_ce) begin
      if (wr_count) begin
        count_q <= i_wdata;
      end else if (inc) begin
        count_q <= count_q + COUNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      option_q <= RST_OPTION;
    end else if (i_ce && wr_option) begin
      option_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irqctl_q <= RST_IRQCTL;
    end else if (i_ce) begin
      if (wr_irqctl) begin
        // only software clears the flag, and a wrap in the same cycle wins [RQ13]
        irqctl_q <= i_wdata | (ovf ? (8'h01 << IRQ_FLAG_BIT) : 8'h00);
      end else if (ovf) begin
        irqctl_q[IRQ_FLAG_BIT] <= 1'b1; // [RQ11]
      end
    end
  end

  // ----------------------------------------------------------------
  // event status and mask
  // ----------------------------------------------------------------
  assign wdt_evt = psc_wdt ? psc_pulse : i_wdt_tick;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      evt_q <= RST_EVT;
    end else if (i_ce) begin
      if (rd_evt) begin
        evt_q <= RST_EVT;
      end
      if (ovf) begin
        evt_q[EVT_OVF_BIT] <= 1'b1;
      end
      if (wdt_evt) begin
        evt_q[EVT_WDT_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mask_q <= RST_EVT;
    end else if (i_ce && wr_mask) begin
      mask_q <= i_wdata;
    end
  end

  // [RQ12]
  assign o_irq = (irqctl_q[IRQ_FLAG_BIT] & irqctl_q[IRQ_EN_BIT]) | (|(evt_q & mask_q));

  // ----------------------------------------------------------------
  // watchdog tick out
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wdt_out_q <= 1'b0;
    end else if (i_ce) begin
      wdt_out_q <= wdt_evt; // [RQ5]
    end
  end

  assign o_wdt_tick = wdt_out_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      if (i_rd && i_addr == ADDR_COUNT) begin
        rdata_q <= count_q;
      end else if (i_rd && i_addr == ADDR_IRQCTL) begin
        rdata_q <= irqctl_q;
      end else if (i_rd && i_addr == ADDR_OPTION) begin
        rdata_q <= option_q;
      end else if (rd_evt) begin
        rdata_q <= evt_q;
      end else if (i_rd && i_addr == ADDR_EVT_MASK) begin
        rdata_q <= mask_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_ovf_flag;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && ovf) |=> (irqctl_q[IRQ_FLAG_BIT] && count_q == 8'h00);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("wrap did not set flag"); // [RQ11]

  property p_inhibit_len;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && wr_count) |=> (inhibit_q != INHIBIT_ZERO) [*8];
  endproperty
  a_inhibit_len: assert property (p_inhibit_len) else $error("inhibit too short"); // [RQ2]

  property p_inhibit_hold;
    @(posedge i_clk) disable iff (i_reset)
    (inhibit_q != INHIBIT_ZERO && !wr_count) |=> (count_q == $past(count_q));
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved in inhibit"); // [RQ2]

  property p_irq_masked;
    @(posedge i_clk) disable iff (i_reset)
    (!irqctl_q[IRQ_EN_BIT] && (evt_q & mask_q) == 8'h00) |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised"); // [RQ12]

  property p_sleep_stop;
    @(posedge i_clk) disable iff (i_reset)
    (i_sleep && !wr_count) |=> (count_q == $past(count_q));
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("count moved in sleep"); // [RQ14]

  property p_psc_clr_tmr;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && wr_count && !psc_wdt) |=> (u_psc.cnt_q == PSC_ZERO && option_q == $past(option_q));
  endproperty
  a_psc_clr_tmr: assert property (p_psc_clr_tmr) else $error("write kept prescaler"); // [RQ9]

  property p_psc_clr_wdt;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && i_watchdog_clear_instr && psc_wdt) |=> (u_psc.cnt_q == PSC_ZERO);
  endproperty
  a_psc_clr_wdt: assert property (p_psc_clr_wdt) else $error("clear kept prescaler"); // [RQ10]

  property p_wdt_bypass;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && !psc_wdt) |=> (o_wdt_tick == $past(i_wdt_tick));
  endproperty
  a_wdt_bypass: assert property (p_wdt_bypass) else $error("watchdog tick divided"); // [RQ5]

  property p_sample_phase;
    @(posedge i_clk) disable iff (i_reset)
    (count_q != $past(count_q) && !$past(wr_count))
      |-> ($past(phase_q) == PH_Q2 || $past(phase_q) == PH_Q4);
  endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("count off sample phase"); // [RQ15]

endmodule

// *** core/tmr0sp_pkg.sv ***
/*
  constants, register map and phase encoding for the shared-prescaler timer.
  assumes a single 50 mhz clock, one clock per oscillator period.
*/
package tmr0sp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT = 8'h01;
  localparam logic [7:0] ADDR_IRQCTL = 8'h0B;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h0D;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OPT_SRC_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATIO_MSB = 2;
  localparam int OPT_RATIO_LSB = 0;
  localparam int IRQ_EN_BIT = 5;
  localparam int IRQ_FLAG_BIT = 2;
  localparam int EVT_OVF_BIT = 0;
  localparam int EVT_WDT_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_IRQCTL = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_EVT = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // prescaler shape
  // ----------------------------------------------------------------
  localparam int PSC_W = 8;
  localparam int SHIFT_W = 4;
  localparam logic [SHIFT_W-1:0] SHIFT_ONE = 4'h1;
  localparam logic [PSC_W-1:0] PSC_ZERO = 8'h00;
  localparam logic [PSC_W-1:0] PSC_ONE = 8'h01;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int INSTR_PERIOD_NS = 80;
  localparam int CLKS_PER_INSTR = (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INHIBIT_INSTRS = 2;
  localparam logic [3:0] INHIBIT_CLKS = 4'(INHIBIT_INSTRS * CLKS_PER_INSTR);
  localparam logic [3:0] INHIBIT_ZERO = 4'h0;
  localparam logic [3:0] INHIBIT_ONE = 4'h1;

  // ----------------------------------------------------------------
  // instruction-cycle phases, gray along the cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } tmr0sp_phase_t;

endpackage

// *** core/tmr0sp_prescaler.sv ***
/*
  shared 8-bit prescaler: counts input ticks, gives a divided level and a
  divided pulse. assumes the caller picks the shift and the clear source.
*/
`timescale 1ns/1ps
module tmr0sp_prescaler
  import tmr0sp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic i_level,
  input wire logic [SHIFT_W-1:0] i_shift,
  output logic o_level,
  output logic o_pulse
);

  // ----------------------------------------------------------------
  // hidden count
  // ----------------------------------------------------------------
  logic [PSC_W-1:0] cnt_q;
  logic [PSC_W-1:0] mask;
  logic [2:0] sel;
  logic full;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q <= PSC_ZERO;
    end else if (i_ce) begin
      if (i_clear) begin
        cnt_q <= PSC_ZERO;
      end else if (i_tick) begin
        cnt_q <= cnt_q + PSC_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // ratio mask, one bit per stage
  // ----------------------------------------------------------------
  for (genvar b = 0; b < PSC_W; b++) begin : g_mask
    assign mask[b] = (i_shift > SHIFT_W'(b));
  end

  assign full = ((cnt_q & mask) == mask);
  assign sel = 3'(i_shift - SHIFT_ONE);
  // shift zero passes the input straight through
  assign o_pulse = i_tick & full;
  assign o_level = (i_shift == '0) ? i_level : cnt_q[sel];

endmodule

// *** bench/tmr0sp_pulse_src.sv ***
/*
  external pulse source that drives the timer's count input pin.
  assumes its tasks are called from the bench sequence at a rising edge.
*/
`timescale 1ns/1ps
module tmr0sp_pulse_src (
  input wire logic i_clk,
  output logic o_pin
);
  // ----------------------------------------------------------------
  // pin driver, low outside frames
  // ----------------------------------------------------------------
  initial o_pin = 1'b0;

  // set a level and hold it two periods or more
  task automatic drive(input logic v, input int hold);
    int n;
    n = (hold < 2) ? 2 : hold;
    o_pin <= v;
    repeat (n) @(posedge i_clk);
  endtask

  // whole pulses, high then low
  task automatic pulses(input int cnt, input int w);
    for (int i = 0; i < cnt; i++) begin
      drive(1'b1, w);
      drive(1'b0, w);
    end
  endtask
endmodule

// *** bench/tmr0sp_tb.sv ***
/*
  self-checking bench for the shared-prescaler timer.
  assumes the timer core, its package and the pulse source model.
*/
`timescale 1ns/1ps
module testbench;
  import tmr0sp_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clk, rst, ce, wr, rd, sleep, wtick, wclr, wtick_out, irq, pin, irq_seen;
  logic [7:0] addr, wdata, rdata, rd_seen;
  int fail_count, checked, wdt_seen;

  tmr0sp_timer tmr0sp_timer_inst (
    .i_clk(clk),
    .i_reset(rst),
    .i_ce(ce),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata),
    .i_ext_count_input(pin),
    .i_sleep(sleep),
    .i_wdt_tick(wtick),
    .i_watchdog_clear_instr(wclr),
    .o_wdt_tick(wtick_out),
    .o_irq(irq)
  );

  tmr0sp_pulse_src tmr0sp_pulse_src_inst (
    .i_clk(clk),
    .o_pin(pin)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // settled snapshots and a count of divided watchdog ticks
  always @(negedge clk) begin
    rd_seen <= rdata;
    irq_seen <= irq;
  end
  always @(posedge clk) begin
    if (wtick_out === 1'b1) wdt_seen <= wdt_seen + 1;
  end

  // ----------------------------------------------------------------
  // bus cycles, compare and verdict
  // ----------------------------------------------------------------
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    cyc(1'b0, 1'b1, a, 8'h00);
    idle(1);
    v = rd_seen;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] v;
    logic [7:0] a [5] = '{ADDR_COUNT, ADDR_IRQCTL, ADDR_OPTION, ADDR_EVT_STATUS, ADDR_EVT_MASK};
    logic [7:0] e [5] = '{RST_COUNT, RST_IRQCTL, RST_OPTION, RST_EVT, RST_EVT};
    for (int i = 0; i < 5; i++) begin
      rd_reg(a[i], v);
      chk("reset value", e[i], v);
    end
    wr_reg(8'h02, 8'h5A);
    rd_reg(8'h02, v);
    chk("unmapped read", 8'h00, v);
    wr_reg(ADDR_OPTION, 8'hA5);
    rd_reg(ADDR_OPTION, v);
    chk("option readback", 8'hA5, v);
  endtask

  task automatic t_inhibit;
    wr_reg(ADDR_OPTION, 8'h08);
    wr_reg(ADDR_COUNT, 8'h10);
    for (int i = 0; i < 8; i++) begin
      cyc(1'b0, i < 7, ADDR_COUNT, 8'h00);
      if (i > 0) chk("count held", 8'h10, rd_seen);
    end
  endtask

  task automatic t_ratio;
    logic [7:0] v0, v1;
    int p;
    for (int k = -1; k < 8; k++) begin
      p = (k < 0) ? 4 : 4 << (k + 1);
      wr_reg(ADDR_OPTION, (k < 0) ? 8'h08 : 8'(k));
      wr_reg(ADDR_COUNT, 8'h00);
      idle(16);
      rd_reg(ADDR_COUNT, v0);
      idle(2 * p - 2);
      rd_reg(ADDR_COUNT, v1);
      chk("count step", 8'h02, v1 - v0);
    end
  endtask

  task automatic t_psc_clear;
    logic [7:0] v, v0;
    wr_reg(ADDR_OPTION, 8'h07);
    wr_reg(ADDR_COUNT, 8'h00);
    idle(600);
    rd_reg(ADDR_COUNT, v0);
    idle(98);
    wr_reg(ADDR_COUNT, 8'h40);
    idle(600);
    rd_reg(ADDR_COUNT, v);
    chk("count after clear", v0 + 8'h40, v);
    rd_reg(ADDR_OPTION, v);
    chk("option kept", 8'h07, v);
  endtask

  task automatic t_ext;
    logic [7:0] v;
    for (int e = 0; e < 2; e++) begin
      wr_reg(ADDR_OPTION, 8'(32'h28 | (e << 4)));
      wr_reg(ADDR_COUNT, 8'h00);
      idle(12);
      tmr0sp_pulse_src_inst.drive(1'b1, 4);
      rd_reg(ADDR_COUNT, v);
      chk("count after rise", 8'(1 - e), v);
      tmr0sp_pulse_src_inst.drive(1'b0, 4);
      rd_reg(ADDR_COUNT, v);
      chk("count after fall", 8'h01, v);
      tmr0sp_pulse_src_inst.pulses(3, 3);
      idle(4);
      rd_reg(ADDR_COUNT, v);
      chk("count after pulses", 8'h04, v);
    end
    wr_reg(ADDR_OPTION, 8'h20);
    wr_reg(ADDR_COUNT, 8'h00);
    idle(12);
    tmr0sp_pulse_src_inst.pulses(4, 3);
    idle(4);
    rd_reg(ADDR_COUNT, v);
    chk("prescaled ext count", 8'h02, v);
  endtask

  task automatic t_wdt;
    int s;
    for (int k = -1; k < 8; k++) begin
      wr_reg(ADDR_COUNT, 8'h00);
      wr_reg(ADDR_OPTION, (k < 0) ? 8'h00 : 8'(8 + k));
      // a stray tick moves the prescaler off a period boundary
      wtick <= 1'b1;
      @(posedge clk);
      wtick <= 1'b0;
      wclr <= 1'b1;
      @(posedge clk);
      wclr <= 1'b0;
      @(posedge clk);
      s = wdt_seen;
      for (int i = 0; i < ((k < 0) ? 4 : (2 << k) - 1); i++) begin
        wtick <= 1'b1;
        @(posedge clk);
        wtick <= 1'b0;
        @(posedge clk);
      end
      idle(4);
      chk("watchdog ticks", (k < 0) ? 8'h04 : 8'h01, 8'(wdt_seen - s));
    end
  endtask

  task automatic t_irq;
    logic [7:0] v;
    wr_reg(ADDR_IRQCTL, 8'h00);
    wr_reg(ADDR_EVT_MASK, 8'h00);
    wr_reg(ADDR_OPTION, 8'h08);
    rd_reg(ADDR_EVT_STATUS, v);
    wr_reg(ADDR_COUNT, 8'hFE);
    idle(24);
    chk("irq masked", 8'h00, {7'h00, irq_seen});
    rd_reg(ADDR_IRQCTL, v);
    chk("overflow flag", 8'h04, v);
    wr_reg(ADDR_IRQCTL, 8'h24);
    idle(1);
    chk("irq enabled", 8'h01, {7'h00, irq_seen});
    wr_reg(ADDR_IRQCTL, 8'h20);
    idle(1);
    chk("irq after flag clear", 8'h00, {7'h00, irq_seen});
    wr_reg(ADDR_EVT_MASK, 8'h01);
    idle(1);
    chk("event irq", 8'h01, {7'h00, irq_seen});
    rd_reg(ADDR_EVT_STATUS, v);
    chk("event status", 8'h01, v);
    chk("event irq cleared", 8'h00, {7'h00, irq_seen});
  endtask

  task automatic t_sleep;
    logic [7:0] v;
    wr_reg(ADDR_OPTION, 8'h08);
    wr_reg(ADDR_COUNT, 8'h20);
    sleep <= 1'b1;
    idle(40);
    rd_reg(ADDR_COUNT, v);
    chk("count in sleep", 8'h20, v);
    ce <= 1'b0;
    sleep <= 1'b0;
    idle(40);
    ce <= 1'b1;
    rd_reg(ADDR_COUNT, v);
    chk("count with clock held", 8'h20, v);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sleep = 1'b0;
    wtick = 1'b0;
    wclr = 1'b0;
    fail_count = 0;
    checked = 0;
    wdt_seen = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_inhibit();
    t_ratio();
    t_psc_clear();
    t_ext();
    t_wdt();
    t_irq();
    t_sleep();
    report_and_stop();
  end
endmodule
